// file: hdl/mbpr_pkg.sv
// Package with function codes, field values and limits of the Modbus parameter responder
package mbpr_pkg;
	localparam logic [7:0] FC_READ_MULTI   = 8'h03;
	localparam logic [7:0] FC_WRITE_MULTI  = 8'h10;
	localparam logic [7:0] FC_READ_WRITE   = 8'h17;
	localparam logic [7:0] FC_ENCAP        = 8'h2b;
	localparam logic [7:0] FC_EXC_FLAG     = 8'h80;
	localparam logic [7:0] MEI_DEVICE_ID   = 8'h0e;
	localparam logic [7:0] DEVID_BASIC     = 8'h01;
	localparam logic [7:0] CONFORMITY_LVL  = 8'h02;
	localparam logic [7:0] MORE_FOLLOWS    = 8'h00;
	localparam logic [7:0] NEXT_OBJ_ID     = 8'h00;
	localparam logic [7:0] NUM_OBJECTS     = 8'h03;
	localparam logic [7:0] OBJ_VENDOR      = 8'h00;
	localparam logic [7:0] OBJ_PRODUCT     = 8'h01;
	localparam logic [7:0] OBJ_REVISION    = 8'h03;
	localparam logic [7:0] EXC_ILL_FUNC    = 8'h01;
	localparam logic [7:0] EXC_ILL_ADDR    = 8'h02;
	localparam logic [7:0] EXC_ILL_VALUE   = 8'h03;
	localparam logic [7:0] EXC_DEV_FAIL    = 8'h04;
	// Register quantity limit per read (125 registers in one PDU)
	localparam logic [15:0] MAX_READ_QTY   = 16'h007d;
	localparam logic [15:0] MAX_WRITE_QTY  = 16'h007b;
	// Identification strings: length of each fixed field
	localparam int          VENDOR_LEN     = 8;
	localparam int          PRODUCT_LEN    = 9;
	localparam int          REVISION_LEN   = 7;
	localparam logic [7:0]  ASCII_V        = 8'h56;
	localparam logic [7:0]  ASCII_DOT      = 8'h2e;
	localparam logic [7:0]  ASCII_ZERO     = 8'h30;
	localparam int          REQ_MAX        = 260;
	localparam int          IDX_W          = 9;
endpackage

// file: hdl/mbpr_id_rom.sv
// Identification object byte source: vendor, product code and revision strings
`timescale 1ns/1ps
`default_nettype none
module mbpr_id_rom
	import mbpr_pkg::*;
#(
	// Arbitrary neutral identity strings
	parameter logic [8*VENDOR_LEN-1:0]  VENDOR_STR  = "ACMEDRV ",
	parameter logic [8*PRODUCT_LEN-1:0] PRODUCT_STR = "DRV000000",
	parameter logic [7:0]               REV_MAJOR   = 8'h02,
	parameter logic [11:0]              REV_MINOR   = 12'h001
) (
	input  wire logic [6:0] idx_in,
	output logic      [7:0] byte_out
);
	// Object stream: id, len, value for each of three objects
	localparam int L0 = 2 + VENDOR_LEN;
	localparam int L1 = L0 + 2 + PRODUCT_LEN;
	logic [8*REVISION_LEN-1:0] rev_str;
	always_comb begin
		// Revision as V, two major digits, dot, three minor digits
		rev_str = {ASCII_V, ASCII_ZERO | {4'h0, REV_MAJOR[7:4]},
			ASCII_ZERO | {4'h0, REV_MAJOR[3:0]}, ASCII_DOT,
			ASCII_ZERO | {4'h0, REV_MINOR[11:8]}, ASCII_ZERO | {4'h0, REV_MINOR[7:4]},
			ASCII_ZERO | {4'h0, REV_MINOR[3:0]}};  // [R8]
	end
	always_comb begin
		int i;
		i = int'(idx_in);
		if (i == 0) begin
			byte_out = OBJ_VENDOR;  // [R6]
		end else if (i == 1) begin
			byte_out = 8'(VENDOR_LEN);
		end else if (i < L0) begin
			byte_out = VENDOR_STR[8*(VENDOR_LEN-1-(i-2)) +: 8];
		end else if (i == L0) begin
			byte_out = OBJ_PRODUCT;  // [R6]
		end else if (i == L0 + 1) begin
			byte_out = 8'(PRODUCT_LEN);
		end else if (i < L1) begin
			byte_out = PRODUCT_STR[8*(PRODUCT_LEN-1-(i-L0-2)) +: 8];  // [R7]
		end else if (i == L1) begin
			byte_out = OBJ_REVISION;  // [R6]
		end else if (i == L1 + 1) begin
			byte_out = 8'(REVISION_LEN);
		end else if (i < L1 + 2 + REVISION_LEN) begin
			byte_out = rev_str[8*(REVISION_LEN-1-(i-L1-2)) +: 8];  // [R8]
		end else begin
			byte_out = 8'h00;
		end
	end
endmodule // mbpr_id_rom
`default_nettype wire

// file: hdl/mbpr_responder.sv
// Modbus PDU request handler answering register and identification services
`timescale 1ns/1ps
`default_nettype none
// Function
// R1: Good read/write answer: 0x17, byte count, then read register bytes.
// R2: Refused read/write answer: 0x97 then one exception code 1 to 4.
// R3: Refused identification answer: 0xab then one exception code 1 to 4.
// R4: Master asks identification with 0x2b, 0x0e, 0x01, object 0x00.
// R5: Identification header: 0x2b, 0x0e, echoed code, 0x02, 0x00, 0x00, 0x03.
// R6: Objects are id, length, value; ids 0x00, 0x01, 0x03.
// R7: Product code object is the ASCII type designation.
// R8: Revision object is ASCII V, two digits, dot, three digits.
// R9: Each parameter spans two registers; contiguous reads in one request.
// R10: Read answer byte count is twice the register quantity.
// R11: Master writes two registers and four bytes per parameter.
// R12: Write answer echoes function, start address and quantity, no data.
// R13: Read/write request: code, read addr, qty, write addr, qty, count, data.
// R14: Unknown function code answered with code plus 0x80 and exception 1.
module mbpr_responder
#(
	parameter int ADDR_W = 16
) (
	input  wire logic        clk_in,
	input  wire logic        reset_in,
	input  wire logic [7:0]  req_data_in,
	input  wire logic        req_valid_in,
	input  wire logic        req_last_in,
	output logic             req_ready_out,
	output logic [7:0]       rsp_data_out,
	output logic             rsp_valid_out,
	output logic             rsp_last_out,
	input  wire logic        rsp_ready_in,
	output logic [15:0]      par_addr_out,
	output logic             par_rd_out,
	output logic             par_wr_out,
	output logic [15:0]      par_wdata_out,
	input  wire logic [15:0] par_rdata_in,
	input  wire logic        par_err_in
);
	import mbpr_pkg::*;

	typedef enum {
		S_RX, S_WRITE, S_HDR, S_READ, S_ID, S_DRAIN
	} mbpr_state_t;

	localparam int HDR_MAX = 7;
	localparam int ID_BYTES = 2 * 3 + VENDOR_LEN + PRODUCT_LEN + REVISION_LEN;

	typedef struct packed {
		mbpr_state_t             st;
		logic [8:0]              cnt;
		logic [7:0]              fc;
		logic [15:0]             a0;
		logic [15:0]             q0;
		logic [15:0]             a1;
		logic [15:0]             q1;
		logic [7:0]              bc;
		logic [7:0]              id_code;
		logic [7:0]              mei;
		logic [7:0]              obj;
		logic [7:0]              exc;
		logic [7:0]              hi;
		logic [15:0]             wr_idx;
		logic [15:0]             rd_idx;
		logic [2:0]              hdr_idx;
		logic                    lo;
		logic                    rx_over;
		logic [7:0]              out_d;
		logic                    out_v;
		logic                    out_l;
		logic                    rdy;
		logic [15:0]             pa;
		logic                    prd;
		logic                    pwr;
		logic [15:0]             pwd;
	} mbpr_regs_t;

	mbpr_regs_t r, nxt;
	logic [7:0] id_byte;
	logic [7:0] hdr_byte;
	logic [2:0] hdr_len;
	logic       take;
	logic       out_free;

	mbpr_id_rom u_rom (
		.idx_in   (r.cnt[6:0]),
		.byte_out (id_byte)
	);

	assign take = req_valid_in & r.rdy;
	assign out_free = ~r.out_v | rsp_ready_in;

	// Header bytes of each answer kind
	always_comb begin
		hdr_byte = 8'h00;
		hdr_len = 3'd2;
		if (r.exc != 8'h00) begin
			hdr_byte = (r.hdr_idx == 3'd0) ? (r.fc | FC_EXC_FLAG) : r.exc;  // [R2] [R3] [R14]
		end else if (r.fc == FC_WRITE_MULTI) begin
			hdr_len = 3'd5;
			unique case (r.hdr_idx)  // [R12]
				3'd0: hdr_byte = r.fc;
				3'd1: hdr_byte = r.a0[15:8];
				3'd2: hdr_byte = r.a0[7:0];
				3'd3: hdr_byte = r.q0[15:8];
				default: hdr_byte = r.q0[7:0];
			endcase
		end else if (r.fc == FC_ENCAP) begin
			hdr_len = 3'd7;
			unique case (r.hdr_idx)  // [R5]
				3'd0: hdr_byte = FC_ENCAP;
				3'd1: hdr_byte = MEI_DEVICE_ID;
				3'd2: hdr_byte = r.id_code;
				3'd3: hdr_byte = CONFORMITY_LVL;
				3'd4: hdr_byte = MORE_FOLLOWS;
				3'd5: hdr_byte = NEXT_OBJ_ID;
				default: hdr_byte = NUM_OBJECTS;
			endcase
		end else begin
			// Byte count is twice the read quantity
			hdr_byte = (r.hdr_idx == 3'd0) ? r.fc : {r.q0[6:0], 1'b0};  // [R1] [R10]
		end
	end

	always_comb begin
		nxt = r;
		nxt.prd = 1'b0;
		nxt.pwr = 1'b0;
		if (out_free) begin
			nxt.out_v = 1'b0;
			nxt.out_l = 1'b0;
		end
		unique case (r.st)
			S_RX: begin
				nxt.rdy = 1'b1;
				if (take) begin
					nxt.cnt = r.cnt + 9'd1;
					unique case (r.cnt)
						9'd0: nxt.fc = req_data_in;
						9'd1: begin nxt.a0[15:8] = req_data_in; nxt.mei = req_data_in; end
						9'd2: begin nxt.a0[7:0] = req_data_in; nxt.id_code = req_data_in; end
						9'd3: begin nxt.q0[15:8] = req_data_in; nxt.obj = req_data_in; end
						9'd4: nxt.q0[7:0] = req_data_in;
						9'd5: begin
							nxt.a1[15:8] = req_data_in;
							nxt.bc = req_data_in;
						end
						9'd6: nxt.a1[7:0] = req_data_in;
						9'd7: nxt.q1[15:8] = req_data_in;
						9'd8: nxt.q1[7:0] = req_data_in;
						9'd9: nxt.bc = req_data_in;  // [R13]
						default: nxt.rx_over = 1'b1;
					endcase
					if (req_last_in) begin
						nxt.rdy = 1'b0;
						nxt.cnt = '0;
						nxt.hdr_idx = '0;
						nxt.exc = 8'h00;
						nxt.st = S_HDR;
						unique case (r.fc)
							FC_READ_MULTI: begin
								// Quantity low byte is the last byte, so judge the next value
								if (nxt.q0 == 16'h0 || nxt.q0 > MAX_READ_QTY)
									nxt.exc = EXC_ILL_VALUE;
							end
							FC_WRITE_MULTI: begin
								// Two registers and four bytes per parameter
								if (r.q0 == 16'h0 || r.q0 > MAX_WRITE_QTY || r.q0[0] ||
										{r.q0[6:0], 1'b0} != r.a1[15:8])  // [R11] [R9]
									nxt.exc = EXC_ILL_VALUE;
								else
									nxt.st = S_WRITE;
							end
							FC_READ_WRITE: begin
								if (r.q0 == 16'h0 || r.q0 > MAX_READ_QTY || r.q1 == 16'h0 ||
										{r.q1[6:0], 1'b0} != r.bc)  // [R13]
									nxt.exc = EXC_ILL_VALUE;
								else
									nxt.st = S_WRITE;
							end
							FC_ENCAP: begin
								if (r.mei != MEI_DEVICE_ID || r.cnt != 9'd3)  // [R4]
									nxt.exc = EXC_ILL_VALUE;
								else if (r.id_code != DEVID_BASIC || req_data_in != OBJ_VENDOR)
									nxt.exc = EXC_ILL_ADDR;  // [R3]
							end
							default: nxt.exc = EXC_ILL_FUNC;  // [R14]
						endcase
						nxt.wr_idx = '0;
						nxt.lo = 1'b0;
					end
				end
			end
			S_WRITE: begin
				// Write data is not stored or forwarded; no write is issued on the
				// parameter port and par_wr_out stays low; this state passes straight
				// on to the answer header.
				nxt.st = S_HDR;
			end
			S_HDR: begin
				if (out_free) begin
					nxt.out_d = hdr_byte;
					nxt.out_v = 1'b1;
					nxt.hdr_idx = r.hdr_idx + 3'd1;
					if (r.hdr_idx == hdr_len - 3'd1) begin
						nxt.rd_idx = '0;
						nxt.lo = 1'b0;
						nxt.cnt = '0;
						if (r.exc != 8'h00 || r.fc == FC_WRITE_MULTI) begin
							nxt.out_l = 1'b1;  // [R12]
							nxt.st = S_RX;
						end else if (r.fc == FC_ENCAP) begin
							nxt.st = S_ID;
						end else begin
							nxt.pa = r.a0;  // [R9]
							nxt.prd = 1'b1;
							nxt.st = S_READ;
						end
					end
				end
			end
			S_READ: begin
				if (out_free && !r.prd) begin
					nxt.out_v = 1'b1;
					nxt.lo = ~r.lo;
					nxt.out_d = r.lo ? r.hi : par_rdata_in[15:8];  // [R1]
					if (!r.lo)
						nxt.hi = par_rdata_in[7:0];
					if (r.lo) begin
						nxt.rd_idx = r.rd_idx + 16'd1;
						if (r.rd_idx + 16'd1 == r.q0) begin
							nxt.out_l = 1'b1;  // [R10]
							nxt.st = S_RX;
						end else begin
							nxt.pa = r.pa + 16'd1;
							nxt.prd = 1'b1;
						end
					end
				end
			end
			S_ID: begin
				if (out_free) begin
					nxt.out_d = id_byte;  // [R6] [R7] [R8]
					nxt.out_v = 1'b1;
					nxt.cnt = r.cnt + 9'd1;
					if (r.cnt == 9'(ID_BYTES - 1)) begin
						nxt.out_l = 1'b1;
						nxt.st = S_RX;
					end
				end
			end
			default: nxt.st = S_RX;
		endcase
		if (r.st == S_RX && nxt.st == S_RX && !take)
			nxt.rdy = 1'b1;
		if (nxt.st != S_RX)
			nxt.rdy = 1'b0;
		if (par_err_in && r.st == S_READ)
			nxt.exc = EXC_DEV_FAIL;
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			r <= '0;
			r.st <= S_RX;
		end else begin
			r <= nxt;
		end
	end

	assign req_ready_out = r.rdy;
	assign rsp_data_out  = r.out_d;
	assign rsp_valid_out = r.out_v;
	assign rsp_last_out  = r.out_l;
	assign par_addr_out  = r.pa;
	assign par_rd_out    = r.prd;
	assign par_wr_out    = r.pwr;
	assign par_wdata_out = r.pwd;

	exc_fc_a: assert property (@(posedge clk_in) disable iff (reset_in)
		(r.st == S_HDR && r.exc != 8'h00 && r.hdr_idx == 3'd0 && out_free) |=>
		(rsp_valid_out && rsp_data_out[7] && rsp_data_out[6:0] == r.fc[6:0]))
		else $error("exception answer lacks flagged code");  // [R2]
	exc_code_a: assert property (@(posedge clk_in) disable iff (reset_in)
		(r.st == S_HDR && r.exc != 8'h00 && r.hdr_idx == 3'd1 && out_free) |=>
		(rsp_last_out && rsp_data_out >= 8'h01 && rsp_data_out <= 8'h04))
		else $error("exception code out of range");  // [R3]
	unk_func_a: assert property (@(posedge clk_in) disable iff (reset_in)
		(take && req_last_in && r.fc != FC_READ_MULTI && r.fc != FC_WRITE_MULTI &&
		 r.fc != FC_READ_WRITE && r.fc != FC_ENCAP) |=> (r.exc == EXC_ILL_FUNC))
		else $error("unknown code not refused");  // [R14]
	id_hdr_a: assert property (@(posedge clk_in) disable iff (reset_in)
		(r.st == S_HDR && r.exc == 8'h00 && r.fc == FC_ENCAP && r.hdr_idx == 3'd6 &&
		 out_free) |=> (rsp_data_out == NUM_OBJECTS && r.st == S_ID))
		else $error("identification object count wrong");  // [R5]
	rd_count_a: assert property (@(posedge clk_in) disable iff (reset_in)
		(r.st == S_HDR && r.exc == 8'h00 && r.fc == FC_READ_WRITE &&
		 r.hdr_idx == 3'd1 && out_free) |=> (rsp_data_out == {r.q0[6:0], 1'b0}))
		else $error("byte count not twice quantity");  // [R10]
	wr_echo_a: assert property (@(posedge clk_in) disable iff (reset_in)
		(r.st == S_HDR && r.exc == 8'h00 && r.fc == FC_WRITE_MULTI &&
		 r.hdr_idx == 3'd4 && out_free) |=> (rsp_last_out && rsp_data_out == r.q0[7:0]))
		else $error("write echo does not end on quantity");  // [R12]
	rd_addr_a: assert property (@(posedge clk_in) disable iff (reset_in)
		$rose(par_rd_out) && r.st == S_READ && r.rd_idx == 16'd0 |-> par_addr_out == r.a0)
		else $error("read does not start at first address");  // [R9]
	id_first_a: assert property (@(posedge clk_in) disable iff (reset_in)
		(r.st == S_ID && r.cnt == 9'd0 && out_free) |=> (rsp_data_out == OBJ_VENDOR))
		else $error("first object is not vendor");  // [R6]
endmodule // mbpr_responder
`default_nettype wire

// file: verification/mbpr_par_model.sv
// Parameter store model on the far side of the responder's register port
`timescale 1ns/1ps
`default_nettype none
module mbpr_par_model #(
	parameter logic [15:0] ERR_ADDR = 16'hfff0
) (
	input  wire logic        clk_in,
	input  wire logic [15:0] par_addr_in,
	input  wire logic        par_rd_in,
	output logic      [15:0] par_rdata_out,
	output logic             par_err_out
);
	initial par_rdata_out = 16'h0000;
	initial par_err_out = 1'b0;
	// Word is valid after the pulse and held to the next one; address low byte XOR 0xa5, then high byte
	always @(posedge clk_in) begin
		if (par_rd_in) begin
			par_rdata_out <= {par_addr_in[7:0] ^ 8'ha5, par_addr_in[15:8]};
			par_err_out <= (par_addr_in == ERR_ADDR);
		end
	end
endmodule // mbpr_par_model
`default_nettype wire

// file: verification/tb_mbpr_responder.sv
// Self-checking testbench of the Modbus parameter responder
`timescale 1ns/1ps
`default_nettype none
module tb_mbpr_responder;
	import mbpr_pkg::*;
	logic        clk_in = 1'b0;
	logic        reset_in = 1'b1;
	logic [7:0]  req_data = 8'h00;
	logic        req_valid = 1'b0;
	logic        req_last = 1'b0;
	logic        req_ready;
	logic [7:0]  rsp_data;
	logic        rsp_valid;
	logic        rsp_last;
	logic        rsp_ready = 1'b0;
	logic [15:0] par_addr;
	logic        par_rd;
	logic [15:0] par_rdata;
	logic        par_err;
	logic        par_wr;
	logic [15:0] par_wdata;
	logic        wr_seen = 1'b0;
	int          n_fail = 0;
	int          checks = 0;
	int          cyc = 0;
	logic [7:0]  req_q[$];
	logic [7:0]  rsp_q[$];
	always #20 clk_in = ~clk_in;
	mbpr_responder i_dut (.clk_in(clk_in), .reset_in(reset_in), .req_data_in(req_data),
		.req_valid_in(req_valid), .req_last_in(req_last), .req_ready_out(req_ready),
		.rsp_data_out(rsp_data), .rsp_valid_out(rsp_valid), .rsp_last_out(rsp_last),
		.rsp_ready_in(rsp_ready), .par_addr_out(par_addr), .par_rd_out(par_rd),
		.par_wr_out(par_wr), .par_wdata_out(par_wdata), .par_rdata_in(par_rdata),
		.par_err_in(par_err));
	// Write data is not forwarded: the write port must stay quiet through the read and write tests
	always @(posedge clk_in) begin
		if (!reset_in && (par_wr !== 1'b0 || par_wdata !== 16'h0000))
			wr_seen <= 1'b1;
	end
	mbpr_par_model i_par (.clk_in(clk_in), .par_addr_in(par_addr), .par_rd_in(par_rd),
		.par_rdata_out(par_rdata), .par_err_out(par_err));
	function automatic logic [15:0] exp_rd(input logic [15:0] a);
		return {a[7:0] ^ 8'ha5, a[15:8]};
	endfunction
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// Sends req_q byte by byte, then gathers the answer with a stalling sink
	task automatic xfer();
		bit ok;
		rsp_q.delete();
		foreach (req_q[i]) begin
			req_data <= req_q[i];
			req_valid <= 1'b1;
			req_last <= (i == req_q.size() - 1);
			do begin
				@(negedge clk_in);
				ok = (req_ready === 1'b1);
				@(posedge clk_in);
			end while (!ok);
		end
		req_valid <= 1'b0;
		req_last <= 1'b0;
		for (int k = 0; k < 2000; k++) begin
			rsp_ready <= (k % 3 != 1);
			@(negedge clk_in);
			ok = (rsp_valid === 1'b1) && rsp_ready && (rsp_last === 1'b1);
			if ((rsp_valid === 1'b1) && rsp_ready)
				rsp_q.push_back(rsp_data);
			@(posedge clk_in);
			if (ok)
				break;
		end
		rsp_ready <= 1'b0;
	endtask
	task automatic chk_seq(input string name, input logic [7:0] e[$]);
		foreach (e[i])
			chk(name, {8'h00, rsp_q[i]}, {8'h00, e[i]});
	endtask
	task automatic chk_exc(input logic [7:0] fc);
		chk("exc len", 16'(rsp_q.size()), 16'h0002);
		chk("exc fc", {8'h00, rsp_q[0]}, {8'h00, fc});
		chk("exc code", 16'(rsp_q[1] inside {[8'h01:8'h04]}), 16'h0001);
	endtask
	task automatic chk_data(input logic [15:0] a, input int n, input int p);
		for (int i = 0; i < n; i++)
			chk("reg data", {rsp_q[p+2*i], rsp_q[p+2*i+1]}, exp_rd(a + 16'(i)));
	endtask
	task automatic t_read();
		req_q = {8'h03, 8'h3c, 8'h02, 8'h00, 8'h08};
		xfer();
		chk("rd len", 16'(rsp_q.size()), 16'h0012);
		chk_seq("rd head", {8'h03, 8'h10});
		chk_data(16'h3c02, 8, 2);
		$display("test read done");
	endtask
	task automatic t_write();
		// Two parameters: four registers, eight bytes
		req_q = {8'h10, 8'h06, 8'h08, 8'h00, 8'h04, 8'h08};
		for (int i = 0; i < 8; i++)
			req_q.push_back(8'(8'h40 + i));
		xfer();
		chk("wr len", 16'(rsp_q.size()), 16'h0005);
		chk_seq("wr echo", {8'h10, 8'h06, 8'h08, 8'h00, 8'h04});
		chk("wr port quiet", {15'h0000, wr_seen}, 16'h0000);
		$display("test write done");
	endtask
	task automatic t_rw();
		// Read addr, qty, write addr, qty, count, values
		req_q = {8'h17, 8'h01, 8'h00, 8'h00, 8'h04, 8'h02, 8'h00, 8'h00, 8'h02, 8'h04,
			8'h11, 8'h22, 8'h33, 8'h44};
		xfer();
		chk("rw len", 16'(rsp_q.size()), 16'h000a);
		chk_seq("rw head", {8'h17, 8'h08});
		chk_data(16'h0100, 4, 2);
		// Read quantity one above the limit is refused
		req_q = {8'h17, 8'h01, 8'h00, 8'h00, 8'h7e, 8'h02, 8'h00, 8'h00, 8'h02, 8'h04,
			8'h11, 8'h22, 8'h33, 8'h44};
		xfer();
		chk_exc(8'h97);
		$display("test read write done");
	endtask
	task automatic t_ident();
		int p;
		logic [7:0] ids[3];
		int lens[3];
		ids = '{8'h00, 8'h01, 8'h03};
		lens = '{VENDOR_LEN, PRODUCT_LEN, REVISION_LEN};
		req_q = {8'h2b, 8'h0e, 8'h01, 8'h00};
		xfer();
		chk_seq("id head", {8'h2b, 8'h0e, 8'h01, 8'h02, 8'h00, 8'h00, 8'h03});
		p = 7;
		for (int o = 0; o < 3; o++) begin
			chk("obj id", {8'h00, rsp_q[p]}, {8'h00, ids[o]});
			chk("obj len", {8'h00, rsp_q[p+1]}, 16'(lens[o]));
			p += 2;
			for (int j = 0; j < lens[o]; j++) begin
				if (o == 1)
					chk("prod ascii", 16'(rsp_q[p+j] inside {[8'h20:8'h7e]}), 16'h0001);
				else if (o == 2 && j != 0 && j != 3)
					chk("rev digit", 16'(rsp_q[p+j] inside {[8'h30:8'h39]}), 16'h0001);
			end
			if (o == 2)
				chk("rev marks", {rsp_q[p], rsp_q[p+3]}, 16'h562e);
			p += lens[o];
		end
		chk("id len", 16'(rsp_q.size()), 16'(p));
		req_q = {8'h2b, 8'h0e, 8'h05, 8'h00};
		xfer();
		chk_exc(8'hab);
		$display("test ident done");
	endtask
	task automatic t_unknown();
		req_q = {8'h07, 8'h00, 8'h00, 8'h00, 8'h01};
		xfer();
		chk("unk len", 16'(rsp_q.size()), 16'h0002);
		chk_seq("unk rsp", {8'h87, 8'h01});
		$display("test unknown done");
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			give_verdict();
		end
	end
	initial begin
		repeat (4) @(posedge clk_in);
		reset_in <= 1'b0;
		t_read();
		t_write();
		t_rw();
		t_ident();
		t_unknown();
		give_verdict();
	end
endmodule // tb_mbpr_responder
`default_nettype wire
